// file: icab_core.sv
// Integer core execution datapath and branch sequencer with Avalon-MM slave
`default_nettype none
module icab_core
  import icab_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Bus lock and status
  input wire logic mem_access_in,
  output logic bus_lock_out,
  output logic irq_allow_out,
  output logic trap_out,
  output logic dual_mode_out
);
  icab_flags_t flags_q, flags_d;
  icab_seq_t seq_q, seq_d;
  icab_cmd_t cmd;
  logic [31:0] pc_q, pc_d, tgt_q, tgt_d, rd_mux, wmerge, rdata_q;
  logic [25:0] imm_q;
  logic [4:0] ridx_q, rf_a_addr, rf_wa, fp_wa;
  logic [1:0] sw_q, sw_d;
  logic [31:0] rf_a, rf_b, rf_wd, fp_wd, fp_rd;
  logic [31:0] fp_q [32];
  logic rf_we, fp_we, rvalid_q, locked_q, trap_q, trap_d, exec, wr;
  logic [31:0] zext, sext, hi, op1_ar, op1_lg, cmp_op, logic_res, tgt_long, tgt_short, link;
  logic [32:0] sum;
  logic c30, lcc_pend;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++)
    begin
      be_merge[8*i+:8] = be[i] ? new_v[8*i+:8] : old_v[8*i+:8];
    end
  endfunction

  // Bus decode
  assign wr = avs_write_in;
  assign exec = wr && avs_address_in == OFF_CMD;
  assign cmd = icab_cmd_t'(avs_writedata_in[$bits(icab_cmd_t)-1:0]);
  assign avs_waitrequest_out = avs_read_in && !rvalid_q;
  assign rf_a_addr = (avs_read_in || wr) && avs_address_in == OFF_IDATA ? ridx_q : cmd.src1;
  assign fp_rd = fp_q[(avs_address_in == OFF_FDATA) ? ridx_q : cmd.src1];

  icab_regfile icab_regfile_inst (
    .clk_in(clk_in),
    .rd_a_addr_in(rf_a_addr),
    .rd_b_addr_in(cmd.src2),
    .rd_a_out(rf_a),
    .rd_b_out(rf_b),
    .wr_en_in(rf_we),
    .wr_addr_in(rf_wa),
    .wr_data_in(rf_wd)
  );

  // Operand forming
  assign zext = {16'h0000, imm_q[15:0]};
  assign sext = {{16{imm_q[15]}}, imm_q[15:0]};
  assign hi = {16'h0000, imm_q[15:0]} << HI_SHIFT;
  assign op1_ar = (cmd.imm_sel && (cmd.op == OP_ADDS || cmd.op == OP_ADDU)) ? sext : rf_a;
  assign op1_lg = cmd.imm_sel ? zext : rf_a;
  assign cmp_op = cmd.imm_sel ? {27'h0000000, cmd.src1} : rf_a;
  assign sum = {1'b0, op1_ar} + {1'b0, rf_b};
  assign c30 = op1_ar[31] ^ rf_b[31] ^ sum[31];
  assign lcc_pend = !sum[31];
  assign tgt_long = pc_q + STEP_SINGLE + {{4{imm_q[25]}}, imm_q, 2'b00};
  assign tgt_short = pc_q + STEP_SINGLE + {{14{imm_q[15]}}, imm_q[15:0], 2'b00};
  assign link = pc_q + STEP_SINGLE + (flags_q.dual_mode ? STEP_DUAL : STEP_SINGLE);

  always_comb
  begin
    logic_res = 32'h00000000;
    case (cmd.op)
      OP_AND: logic_res = op1_lg & rf_b;
      OP_ANDNOT: logic_res = ~op1_lg & rf_b;
      OP_OR: logic_res = op1_lg | rf_b;
      OP_XOR: logic_res = op1_lg ^ rf_b;
      OP_ANDH: logic_res = hi & rf_b;
      OP_ANDNOTH: logic_res = ~hi & rf_b;
      OP_ORH: logic_res = hi | rf_b;
      OP_XORH: logic_res = hi ^ rf_b;
      default: logic_res = 32'h00000000;
    endcase
  end

  // Readback mux, also the base for byte-lane merging
  always_comb
  begin
    unique case (avs_address_in)
      OFF_IMM: rd_mux = {6'h00, imm_q};
      OFF_PC: rd_mux = pc_q;
      OFF_FLAGS: rd_mux = {17'h00000, flags_q};
      OFF_RIDX: rd_mux = {27'h0000000, ridx_q};
      OFF_IDATA: rd_mux = rf_a;
      OFF_FDATA: rd_mux = fp_rd;
      OFF_TARGET: rd_mux = tgt_q;
      default: rd_mux = 32'h00000000;
    endcase
  end
  assign wmerge = be_merge(rd_mux, avs_writedata_in, avs_byteenable_in);

  // Execute one instruction per command write
  always_comb
  begin
    flags_d = flags_q;
    pc_d = pc_q;
    seq_d = seq_q;
    tgt_d = tgt_q;
    sw_d = sw_q;
    trap_d = 1'b0;
    rf_we = wr && avs_address_in == OFF_IDATA;
    rf_wa = ridx_q;
    rf_wd = wmerge;
    fp_we = wr && avs_address_in == OFF_FDATA;
    fp_wa = ridx_q;
    fp_wd = wmerge;
    if (wr && avs_address_in == OFF_FLAGS)
    begin
      flags_d = icab_flags_t'(wmerge[$bits(icab_flags_t)-1:0]);
    end
    if (wr && avs_address_in == OFF_PC)
    begin
      pc_d = wmerge;
      seq_d = SEQ_NORMAL;
    end
    if (exec)
    begin
      pc_d = (seq_q == SEQ_DELAY) ? tgt_q : pc_q + STEP_SINGLE;
      seq_d = SEQ_NORMAL;
      if (sw_q != 2'h0)
      begin
        sw_d = sw_q - 2'h1;
        if (sw_q == SW_LAST)
        begin
          flags_d.dual_mode = !flags_q.dual_mode;
        end
      end
      unique case (cmd.op)
        OP_ADDS:
        begin
          rf_we = 1'b1;
          rf_wa = cmd.dest;
          rf_wd = sum[31:0];
          flags_d.overflow_flag = sum[32] ^ c30;
          flags_d.condition_code = sum[31];
        end
        OP_ADDU:
        begin
          rf_we = 1'b1;
          rf_wa = cmd.dest;
          rf_wd = sum[31:0];
          flags_d.overflow_flag = sum[32];
          flags_d.condition_code = sum[32];
        end
        OP_AND, OP_ANDH, OP_ANDNOT, OP_ANDNOTH, OP_OR, OP_ORH, OP_XOR, OP_XORH:
        begin
          rf_we = 1'b1;
          rf_wa = cmd.dest;
          rf_wd = logic_res;
          flags_d.condition_code = (logic_res == 32'h00000000);
        end
        OP_BC, OP_BNC:
        begin
          if (flags_q.condition_code == (cmd.op == OP_BC))
          begin
            pc_d = tgt_long;
          end
        end
        OP_BCT, OP_BNCT:
        begin
          if (flags_q.condition_code == (cmd.op == OP_BCT))
          begin
            seq_d = SEQ_DELAY;
            tgt_d = tgt_long;
          end
          else
          begin
            pc_d = pc_q + STEP_SKIP;
          end
        end
        OP_BR, OP_CALL:
        begin
          seq_d = SEQ_DELAY;
          tgt_d = tgt_long;
          if (cmd.op == OP_CALL)
          begin
            rf_we = 1'b1;
            rf_wa = 5'h01;
            rf_wd = link;
          end
        end
        OP_BLA:
        begin
          rf_we = 1'b1;
          rf_wa = cmd.src2;
          rf_wd = sum[31:0];
          flags_d.loop_condition_flag = lcc_pend;
          if (flags_q.loop_condition_flag)
          begin
            seq_d = SEQ_DELAY;
            tgt_d = tgt_short;
          end
        end
        OP_BRI, OP_CALLI:
        begin
          seq_d = SEQ_DELAY;
          tgt_d = rf_a;
          if (cmd.op == OP_CALLI)
          begin
            rf_we = 1'b1;
            rf_wa = 5'h01;
            rf_wd = link;
          end
          else if (flags_q.trap_bits != 4'h0)
          begin
            flags_d.privilege_flag = flags_q.saved_privilege_flag;
            flags_d.irq_enable_flag = flags_q.saved_irq_gate;
            flags_d.trap_bits = 4'h0;
            if (flags_q.delayed_switch_flag)
            begin
              sw_d = SW_ARM;
            end
            else
            begin
              flags_d.dual_mode = flags_q.dual_issue_flag;
              sw_d = 2'h0;
            end
          end
        end
        OP_BTE, OP_BTNE:
        begin
          if ((cmp_op == rf_b) == (cmd.op == OP_BTE))
          begin
            pc_d = tgt_short;
          end
        end
        OP_INTOVR:
        begin
          if (flags_q.overflow_flag)
          begin
            flags_d.trap_bits[TRAP_IT] = 1'b1;
            trap_d = 1'b1;
          end
        end
        OP_LOCK: flags_d.bus_lock_flag = 1'b1;
        OP_UNLOCK: flags_d.bus_lock_flag = 1'b0;
        OP_FXFR:
        begin
          rf_we = 1'b1;
          rf_wa = cmd.dest;
          rf_wd = fp_rd;
        end
        OP_IXFR:
        begin
          fp_we = 1'b1;
          fp_wa = cmd.dest;
          fp_wd = rf_a;
        end
        default: ;
      endcase
    end
  end

  // Sequencer and flag state
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      flags_q <= FLAGS_RST;
      pc_q <= PC_RST;
      tgt_q <= PC_RST;
      seq_q <= SEQ_NORMAL;
      sw_q <= 2'h0;
      trap_q <= 1'b0;
    end
    else
    begin
      flags_q <= flags_d;
      pc_q <= pc_d;
      tgt_q <= tgt_d;
      seq_q <= seq_d;
      sw_q <= sw_d;
      trap_q <= trap_d;
    end
  end

  // Software-written index and immediate
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      imm_q <= 26'h0000000;
      ridx_q <= 5'h00;
    end
    else if (wr && avs_address_in == OFF_IMM)
    begin
      imm_q <= wmerge[25:0];
    end
    else if (wr && avs_address_in == OFF_RIDX)
    begin
      ridx_q <= wmerge[4:0];
    end
  end

  // Floating register low words
  always_ff @(posedge clk_in)
  begin
    if (fp_we)
    begin
      fp_q[fp_wa] <= fp_wd;
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      rvalid_q <= avs_read_in && !rvalid_q;
      if (avs_read_in && !rvalid_q)
      begin
        rdata_q <= rd_mux;
      end
    end
  end
  assign avs_readdata_out = rdata_q;

  // Bus lock follows the next memory access after lock or unlock
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      locked_q <= 1'b0;
    end
    else if (mem_access_in)
    begin
      locked_q <= flags_q.bus_lock_flag;
    end
  end

  assign bus_lock_out = locked_q;
  assign irq_allow_out = flags_q.irq_enable_flag && !flags_q.bus_lock_flag && !locked_q;
  assign trap_out = trap_q;
  assign dual_mode_out = flags_q.dual_mode;

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_adds_overflow: assert property (exec && cmd.op == OP_ADDS |=>
    flags_q.overflow_flag == ($past(op1_ar[31]) == $past(rf_b[31]) && $past(sum[31]) != $past(rf_b[31])))
    else $error("signed add overflow wrong");
  a_addu_carry: assert property (exec && cmd.op == OP_ADDU |=>
    flags_q.condition_code == flags_q.overflow_flag && flags_q.condition_code == $past(sum[32]))
    else $error("unsigned add carry wrong");
  a_orh_shift: assert property (exec && cmd.op == OP_ORH && rf_b == 32'h00000000 |->
    logic_res[31:16] == imm_q[15:0] && logic_res[15:0] == 16'h0000)
    else $error("high immediate not shifted");
  a_bc_target: assert property (exec && cmd.op == OP_BC && flags_q.condition_code && seq_q == SEQ_NORMAL |=>
    seq_q == SEQ_NORMAL && pc_q == $past(pc_q) + 32'h00000004 + {{4{$past(imm_q[25])}}, $past(imm_q), 2'b00})
    else $error("branch on flag target wrong");
  a_bct_skip: assert property (exec && cmd.op == OP_BCT && !flags_q.condition_code && seq_q == SEQ_NORMAL |=>
    pc_q == $past(pc_q) + 32'h00000008)
    else $error("skip did not pass next instruction");
  a_br_slot: assert property (exec && cmd.op == OP_BR |=>
    seq_q == SEQ_DELAY && pc_q == $past(pc_q) + 32'h00000004 &&
    tgt_q == $past(pc_q) + 32'h00000004 + {{4{$past(imm_q[25])}}, $past(imm_q), 2'b00})
    else $error("direct jump did not arm its slot");
  a_slot_jump: assert property (exec && seq_q == SEQ_DELAY && cmd.op == OP_NOP |=>
    pc_q == $past(tgt_q) && seq_q == SEQ_NORMAL)
    else $error("delay slot not followed by target");
  a_intovr_quiet: assert property (exec && cmd.op == OP_INTOVR && !flags_q.overflow_flag |=>
    !trap_out && flags_q.trap_bits == $past(flags_q.trap_bits))
    else $error("overflow trap without overflow");
  a_lock_irq: assert property (exec && cmd.op == OP_LOCK |=> !irq_allow_out)
    else $error("interrupts open while locked");
  a_bri_restore: assert property (exec && cmd.op == OP_BRI && flags_q.trap_bits != 4'h0 |=>
    flags_q.trap_bits == 4'h0 && flags_q.privilege_flag == $past(flags_q.saved_privilege_flag))
    else $error("trap return restore wrong");

  c_loop_taken: cover property (exec && cmd.op == OP_BLA && flags_q.loop_condition_flag);
  c_trap_return: cover property (exec && cmd.op == OP_BRI && flags_q.delayed_switch_flag && flags_q.trap_bits != 4'h0);
  c_call_dual: cover property (exec && cmd.op == OP_CALL && flags_q.dual_mode);
endmodule
`default_nettype wire

// file: icab_pkg.sv
// Constants, types and map for the integer core ALU and branch unit
//
// Overview of operation
// - Signed add writes sum; overflow is bit31 carry XOR bit30 carry; flag when negative
// - Unsigned add writes sum; overflow and condition both take the bit 31 carry
// - AND, AND-NOT and OR write result; condition set when result is zero
// - High forms shift immediate left 16, inverted for AND-NOT; zero-result flag
// - Branch on flag jumps to long target, no delay slot, when condition matches
// - Taken-predicted branch runs next instruction then jumps, else skips it
// - Direct jump always runs exactly one delay-slot instruction, then long target
// - Loop branch adds, keeps pending flag from sign, branches on old loop flag
// - Indirect branch with trap bits restores privilege and irq gate, clears traps
// - Trap return picks mode: delayed toggle after the slot and one more instruction, else dual-issue flag
// - Indirect branch and call use target captured before slot, no alignment trap
// - Compare-and-branch jumps to short target on equal, or on unequal if negated
// - Calls load link with slot address plus 4, or 8 in dual mode
// - Overflow trap sets software trap flag only when overflow flag is one
// - Begin-interlock sets bus lock, locks next access, holds interrupts off
// - Moves copy floating register to integer register and back unchanged
// - Immediate zero-extends for logic ops, sign-extends for adds and addresses
// - Target is offset shifted left two, sign-extended, plus address plus four
// - Compare immediate is five bits zero-extended to 32 bits
`default_nettype none
package icab_pkg;
  localparam logic [5:0] OFF_CMD = 6'h00;
  localparam logic [5:0] OFF_IMM = 6'h04;
  localparam logic [5:0] OFF_PC = 6'h08;
  localparam logic [5:0] OFF_FLAGS = 6'h0C;
  localparam logic [5:0] OFF_RIDX = 6'h10;
  localparam logic [5:0] OFF_IDATA = 6'h14;
  localparam logic [5:0] OFF_FDATA = 6'h18;
  localparam logic [5:0] OFF_TARGET = 6'h1C;
  localparam logic [31:0] PC_RST = 32'h00000000;
  localparam logic [31:0] STEP_SINGLE = 32'h00000004;
  localparam logic [31:0] STEP_DUAL = 32'h00000008;
  localparam logic [31:0] STEP_SKIP = 32'h00000008;
  localparam int HI_SHIFT = 16;
  localparam int TRAP_IT = 0;
  localparam logic [1:0] SW_ARM = 2'h2;
  localparam logic [1:0] SW_LAST = 2'h1;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADDS, OP_ADDU, OP_AND, OP_ANDH, OP_ANDNOT, OP_ANDNOTH, OP_OR, OP_ORH,
    OP_XOR, OP_XORH, OP_BC, OP_BCT, OP_BNC, OP_BNCT, OP_BR, OP_BLA, OP_BRI, OP_BTE,
    OP_BTNE, OP_CALL, OP_CALLI, OP_INTOVR, OP_LOCK, OP_UNLOCK, OP_FXFR, OP_IXFR
  } icab_op_t;

  typedef struct packed {
    logic imm_sel;
    logic [4:0] src2;
    logic [4:0] src1;
    logic [4:0] dest;
    icab_op_t op;
  } icab_cmd_t;

  typedef struct packed {
    logic [3:0] trap_bits;
    logic bus_lock_flag;
    logic dual_mode;
    logic dual_issue_flag;
    logic delayed_switch_flag;
    logic saved_irq_gate;
    logic irq_enable_flag;
    logic saved_privilege_flag;
    logic privilege_flag;
    logic loop_condition_flag;
    logic overflow_flag;
    logic condition_code;
  } icab_flags_t;

  localparam icab_flags_t FLAGS_RST = 15'h0000;

  typedef enum logic {SEQ_NORMAL, SEQ_DELAY} icab_seq_t;
endpackage
`default_nettype wire

// file: icab_regfile.sv
// Integer register file, two read ports, one write port
`default_nettype none
module icab_regfile
  import icab_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Read ports
  input wire logic [4:0] rd_a_addr_in,
  input wire logic [4:0] rd_b_addr_in,
  output logic [31:0] rd_a_out,
  output logic [31:0] rd_b_out,
  // Write port
  input wire logic wr_en_in,
  input wire logic [4:0] wr_addr_in,
  input wire logic [31:0] wr_data_in
);
  logic [31:0] mem_q [1:31];

  always_ff @(posedge clk_in)
  begin
    if (wr_en_in && wr_addr_in != 5'h00)
    begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  assign rd_a_out = (rd_a_addr_in == 5'h00) ? 32'h00000000 : mem_q[rd_a_addr_in];
  assign rd_b_out = (rd_b_addr_in == 5'h00) ? 32'h00000000 : mem_q[rd_b_addr_in];

  a_zero_reads: assert property (@(posedge clk_in) (rd_a_addr_in == 5'h00) |-> (rd_a_out == 32'h00000000))
    else $error("register zero read nonzero");
endmodule
`default_nettype wire

// file: test_integer_core_alu_branch_unit.sv
// Self-checking bench for the integer core ALU and branch unit
`default_nettype none
module test_integer_core_alu_branch_unit
  import icab_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, rst_in, rd_q, wr_q, mem_q, wait_w, lock_w, irq_w, trap_w, dual_w;
  logic [5:0] addr_q;
  logic [31:0] wdata_q, rdata_w, v, a, b, pc0, tg, seed;
  logic [33:0] e;
  logic [25:0] off;
  logic [4:0] d, s1;
  logic im, cc, tk, dl;
  icab_op_t op;
  int miscompares, comparisons, traps, t0;
  icab_op_t alu_ops[10] = '{OP_ADDS, OP_ADDU, OP_AND, OP_ANDH, OP_ANDNOT, OP_ANDNOTH, OP_OR, OP_ORH, OP_XOR, OP_XORH};
  icab_op_t br_ops[5] = '{OP_BC, OP_BNC, OP_BCT, OP_BNCT, OP_BR};

  icab_core icab_core_inst (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr_q), .avs_read_in(rd_q),
    .avs_write_in(wr_q), .avs_writedata_in(wdata_q), .avs_byteenable_in(4'hF), .avs_readdata_out(rdata_w),
    .avs_waitrequest_out(wait_w), .mem_access_in(mem_q), .bus_lock_out(lock_w), .irq_allow_out(irq_w),
    .trap_out(trap_w), .dual_mode_out(dual_w));

  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Counts cycles with the trap pulse up
  always @(posedge clk_in)
  begin
    if (trap_w === 1'b1)
      traps++;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] brx(input logic [31:0] pc, input logic [25:0] o, input logic lng);
    return lng ? pc + 32'h4 + {{4{o[25]}}, o, 2'b00} : pc + 32'h4 + {{14{o[15]}}, o[15:0], 2'b00};
  endfunction

  // Returns condition, overflow and result
  function automatic logic [33:0] alu_exp(input icab_op_t o, input logic [31:0] x0, input logic [31:0] y,
    input logic [15:0] k, input logic s);
    logic [31:0] x, r;
    logic [32:0] sm;
    x = s ? {16'h0000, k} : x0;
    if (o == OP_ADDS || o == OP_ADDU)
      x = s ? {{16{k[15]}}, k} : x0;
    if (o inside {OP_ANDH, OP_ANDNOTH, OP_ORH, OP_XORH})
      x = {k, 16'h0000};
    sm = {1'b0, x} + {1'b0, y};
    if (o == OP_ADDS)
      return {sm[31], sm[32] ^ x[31] ^ y[31] ^ sm[31], sm[31:0]};
    if (o == OP_ADDU)
      return {sm[32], sm[32], sm[31:0]};
    case (o)
      OP_AND, OP_ANDH: r = x & y;
      OP_ANDNOT, OP_ANDNOTH: r = ~x & y;
      OP_OR, OP_ORH: r = x | y;
      default: r = x ^ y;
    endcase
    return {r == 32'h0, 1'b0, r};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits for the rising edge with waitrequest low, takes read data there
  task automatic ack(output logic [31:0] q);
    @(posedge clk_in);
    while (wait_w !== 1'b0)
      @(posedge clk_in);
    q = rdata_w;
  endtask

  task automatic wr(input logic [5:0] ad, input logic [31:0] dt);
    logic [31:0] q;
    @(posedge clk_in);
    addr_q <= ad;
    wdata_q <= dt;
    wr_q <= 1'b1;
    ack(q);
    wr_q <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] ad, output logic [31:0] q);
    @(posedge clk_in);
    addr_q <= ad;
    rd_q <= 1'b1;
    ack(q);
    rd_q <= 1'b0;
  endtask

  task automatic set_reg(input logic [4:0] i, input logic [31:0] x);
    wr(OFF_RIDX, {27'h0, i});
    wr(OFF_IDATA, x);
  endtask

  task automatic get_reg(input logic [4:0] i, output logic [31:0] q);
    wr(OFF_RIDX, {27'h0, i});
    rd(OFF_IDATA, q);
  endtask

  task automatic cmd(input icab_op_t o, input logic [4:0] dd, input logic [4:0] s, input logic [4:0] t,
    input logic m);
    icab_cmd_t c;
    c = '{m, t, s, dd, o};
    wr(OFF_CMD, {11'h000, c});
  endtask

  task automatic mem_pulse();
    @(posedge clk_in);
    mem_q <= 1'b1;
    @(posedge clk_in);
    mem_q <= 1'b0;
    @(negedge clk_in);
  endtask

  task automatic print_verdict();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    print_verdict();
  end

  initial
  begin
    seed = 32'h00000039;
    rst_in = 1'b1;
    rd_q = 1'b0;
    wr_q = 1'b0;
    mem_q = 1'b0;
    addr_q = 6'h00;
    wdata_q = 32'h0;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(OFF_FLAGS, v);
    chk(v, 32'h0, "flags reset");
    rd(OFF_PC, v);
    chk(v, PC_RST, "pc reset");
    wr(6'h20, 32'hFFFFFFFF);
    rd(6'h20, v);
    chk(v, 32'h0, "unmapped");
    set_reg(0, rnd());
    get_reg(0, v);
    chk(v, 32'h0, "r0 write");
    // Arithmetic and logic, corners first
    for (int i = 0; i < 40; i++)
    begin
      op = alu_ops[i % 10];
      a = rnd();
      b = rnd();
      v = rnd();
      im = v[16] | (op inside {OP_ANDH, OP_ANDNOTH, OP_ORH, OP_XORH});
      d = 5'(32'd4 + rnd() % 32'd28);
      if (i < 3)
      begin
        a = (i == 0) ? 32'h7FFFFFFF : (i == 1) ? 32'hFFFFFFFF : 32'hF0F0F0F0;
        b = (i == 2) ? 32'h0F0F0F0F : 32'h1;
        im = 1'b0;
      end
      if (i == 7)
        b = 32'h0;
      set_reg(2, a);
      set_reg(3, b);
      wr(OFF_IMM, {16'h0000, v[15:0]});
      cmd(op, d, 5'd2, 5'd3, im);
      e = alu_exp(op, a, b, v[15:0], im);
      get_reg(d, v);
      chk(v, e[31:0], "alu result");
      rd(OFF_FLAGS, v);
      chk({31'h0, v[0]}, {31'h0, e[33]}, "condition");
      if (op == OP_ADDS || op == OP_ADDU)
        chk({31'h0, v[1]}, {31'h0, e[32]}, "overflow");
    end
    cmd(OP_OR, 5'd0, 5'd2, 5'd3, 1'b0);
    get_reg(0, v);
    chk(v, 32'h0, "r0 dest");
    // Flag branches and direct jump, both flag values
    for (int k = 0; k < 10; k++)
    begin
      op = br_ops[k / 2];
      cc = k[0];
      off = 26'(rnd());
      pc0 = rnd() & 32'hFFFFFFFC;
      tk = (op == OP_BR) | ((op == OP_BC || op == OP_BCT) ? cc : !cc);
      dl = op inside {OP_BCT, OP_BNCT, OP_BR};
      wr(OFF_FLAGS, {31'h0, cc});
      wr(OFF_PC, pc0);
      wr(OFF_IMM, {6'h00, off});
      cmd(op, 5'd0, 5'd0, 5'd0, 1'b0);
      rd(OFF_PC, v);
      chk(v, !tk ? pc0 + (dl ? 32'h8 : 32'h4) : dl ? pc0 + 32'h4 : brx(pc0, off, 1'b1), "pc");
      rd(OFF_TARGET, v);
      if (dl && tk)
        chk(v, brx(pc0, off, 1'b1), "pending target");
      cmd(OP_NOP, 5'd0, 5'd0, 5'd0, 1'b0);
      rd(OFF_PC, v);
      if (dl && tk)
        chk(v, brx(pc0, off, 1'b1), "slot target");
    end
    // Compare branches on a five-bit immediate
    for (int k = 0; k < 4; k++)
    begin
      op = k[1] ? OP_BTNE : OP_BTE;
      s1 = (k == 0) ? 5'h1F : 5'(rnd());
      off = {10'h000, 16'(rnd())};
      pc0 = rnd() & 32'hFFFFFFFC;
      set_reg(3, k[0] ? {27'h0, s1} : {27'h4000000, s1});
      wr(OFF_PC, pc0);
      wr(OFF_IMM, {6'h00, off});
      cmd(op, 5'd0, s1, 5'd3, 1'b1);
      rd(OFF_PC, v);
      tk = (op == OP_BTE) == k[0];
      chk(v, tk ? brx(pc0, off, 1'b0) : pc0 + 32'h4, "compare pc");
    end
    // Calls in single and dual mode
    for (int k = 0; k < 2; k++)
    begin
      pc0 = rnd() & 32'hFFFFFFFC;
      off = 26'(rnd());
      wr(OFF_FLAGS, k[0] ? 32'h200 : 32'h0);
      wr(OFF_PC, pc0);
      wr(OFF_IMM, {6'h00, off});
      cmd(OP_CALL, 5'd0, 5'd0, 5'd0, 1'b0);
      cmd(OP_NOP, 5'd0, 5'd0, 5'd0, 1'b0);
      get_reg(1, v);
      chk(v, pc0 + 32'h4 + (k[0] ? STEP_DUAL : STEP_SINGLE), "link");
      rd(OFF_PC, v);
      chk(v, brx(pc0, off, 1'b1), "call target");
      chk({31'h0, dual_w}, k, "dual pin");
    end
    // Trap return to a misaligned target overwritten by its slot
    tg = rnd() | 32'h1;
    set_reg(5, tg);
    wr(OFF_FLAGS, 32'h950);
    cmd(OP_BRI, 5'd0, 5'd5, 5'd0, 1'b0);
    cmd(OP_ADDU, 5'd5, 5'd2, 5'd3, 1'b0);
    rd(OFF_PC, v);
    chk(v, tg, "indirect target");
    rd(OFF_FLAGS, v);
    chk({17'h0, v[14:3], 3'b000}, 32'h378, "trap return");
    set_reg(5, tg);
    wr(OFF_FLAGS, 32'h880);
    cmd(OP_BRI, 5'd0, 5'd5, 5'd0, 1'b0);
    cmd(OP_NOP, 5'd0, 5'd0, 5'd0, 1'b0);
    @(negedge clk_in);
    chk({31'h0, dual_w}, 32'h0, "mode after slot");
    cmd(OP_NOP, 5'd0, 5'd0, 5'd0, 1'b0);
    @(negedge clk_in);
    chk({31'h0, dual_w}, 32'h1, "mode toggled");
    tg = rnd() | 32'h2;
    pc0 = rnd() & 32'hFFFFFFFC;
    set_reg(6, tg);
    wr(OFF_FLAGS, 32'h0);
    wr(OFF_PC, pc0);
    cmd(OP_CALLI, 5'd0, 5'd6, 5'd0, 1'b0);
    cmd(OP_OR, 5'd6, 5'd2, 5'd3, 1'b0);
    rd(OFF_PC, v);
    chk(v, tg, "calli target");
    get_reg(1, v);
    chk(v, pc0 + 32'h8, "calli link");
    // Loop branch with old flag set and clear
    for (int k = 0; k < 4; k++)
    begin
      a = rnd();
      b = rnd();
      pc0 = rnd() & 32'hFFFFFFFC;
      off = {10'h000, 16'(rnd())};
      set_reg(2, a);
      set_reg(3, b);
      wr(OFF_FLAGS, {29'h0, k[0], 2'b00});
      wr(OFF_PC, pc0);
      wr(OFF_IMM, {6'h00, off});
      cmd(OP_BLA, 5'd0, 5'd2, 5'd3, 1'b1);
      cmd(OP_NOP, 5'd0, 5'd0, 5'd0, 1'b0);
      rd(OFF_PC, v);
      chk(v, k[0] ? brx(pc0, off, 1'b0) : pc0 + 32'h8, "loop pc");
      rd(OFF_FLAGS, v);
      chk({31'h0, v[2]}, 32'((~(a + b)) >> 31), "loop flag");
      get_reg(3, v);
      chk(v, a + b, "loop sum");
    end
    // Overflow trap with the flag clear and set
    for (int k = 0; k < 2; k++)
    begin
      wr(OFF_FLAGS, {30'h0, k[0], 1'b0});
      t0 = traps;
      cmd(OP_INTOVR, 5'd0, 5'd0, 5'd0, 1'b0);
      rd(OFF_FLAGS, v);
      chk(traps - t0, k, "trap pulses");
      chk({31'h0, v[11]}, k, "trap flag");
    end
    // Interlock around two bus accesses
    wr(OFF_FLAGS, 32'h20);
    cmd(OP_LOCK, 5'd0, 5'd0, 5'd0, 1'b0);
    @(negedge clk_in);
    chk({30'h0, lock_w, irq_w}, 32'h0, "lock armed");
    rd(OFF_FLAGS, v);
    chk({31'h0, v[10]}, 32'h1, "lock flag");
    mem_pulse();
    chk({30'h0, lock_w, irq_w}, 32'h2, "bus locked");
    cmd(OP_UNLOCK, 5'd0, 5'd0, 5'd0, 1'b0);
    @(negedge clk_in);
    chk({30'h0, lock_w, irq_w}, 32'h2, "still locked");
    mem_pulse();
    chk({30'h0, lock_w, irq_w}, 32'h1, "unlocked");
    // Register file transfers
    a = rnd();
    b = rnd();
    wr(OFF_RIDX, 32'h7);
    wr(OFF_FDATA, a);
    cmd(OP_FXFR, 5'd9, 5'd7, 5'd0, 1'b0);
    get_reg(9, v);
    chk(v, a, "fp to int");
    set_reg(2, b);
    cmd(OP_IXFR, 5'd8, 5'd2, 5'd0, 1'b0);
    wr(OFF_RIDX, 32'h8);
    rd(OFF_FDATA, v);
    chk(v, b, "int to fp");
    print_verdict();
  end
endmodule
`default_nettype wire
